// ---- hw/dsw_port.v ----
// Serial write port of a single-channel DAC: frame select, serial clock, data.
// Assumes all three pins are asynchronous to clk_in and the serial clock is
// at most a third of clk_in; the pins are sampled and edges found here.
`timescale 1ns/1ps
`include "dsw_map.vh"
// What this block does
// [RULE1] Shift register of 16 or 24 bits
// [RULE2] Sample data on serial clock falling edges
// [RULE3] Low frame select enables shifting
// [RULE4] Apply word on last edge of frame
// [RULE5] Early frame select rise discards frame
// [RULE6] Host keeps serial clock at most 30 MHz
// [RULE7] Host returns frame select high between frames
// [RULE8] Word sets DAC code or operating mode; here every word loads both the code and the mode
// [RULE9] Short variant completes in 16 clock periods
// [RULE10] Bit counter clears after frame ends
module dsw_port #(
  parameter LONG_FRAME = 1
) (
  input wire clk_in,
  input wire reset_in,
  input wire frame_n_in,
  input wire sclk_in,
  input wire din_in,
  output reg [`DSW_CODE_W-1:0] dac_code_out,
  output reg [`DSW_MODE_W-1:0] mode_out,
  output reg update_out,
  output reg abort_out,
  output reg busy_out
);
  localparam [`DSW_CNT_W-1:0] FRAME_BITS =
    LONG_FRAME ? `DSW_BITS_LONG : `DSW_BITS_SHORT;
  localparam ST_IDLE = 2'h0;
  localparam ST_SHIFT = 2'h1;
  localparam ST_DONE = 2'h2;

  wire frame_n_s;
  wire sclk_s;
  wire din_s;
  reg sclk_d;
  reg frame_n_d;
  reg [1:0] state;
  reg [1:0] next_state;
  reg [`DSW_CNT_W-1:0] bit_cnt;
  reg [`DSW_SHIFT_W-1:0] shift;
  wire [`DSW_SHIFT_W-1:0] shifted;

  // The short variant shares the pins; its frame sits in the low 16 bits.
  // Frame select idles high; starting low would fake a frame start after reset
  dsw_sync #(
    .RESET_VAL(1'b1)
  ) u_frame (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .pin_in(frame_n_in),
    .level_out(frame_n_s)
  );

  // Serial clock idles high between frames
  dsw_sync #(
    .RESET_VAL(1'b1)
  ) u_sclk (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .pin_in(sclk_in),
    .level_out(sclk_s)
  );

  dsw_sync #(
    .RESET_VAL(1'b0)
  ) u_din (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .pin_in(din_in),
    .level_out(din_s)
  );

  // Data passes the same two stages as the clock, so it stays aligned
  wire sclk_fall = sclk_d & ~sclk_s;
  wire frame_fall = frame_n_d & ~frame_n_s;
  assign shifted = {shift[`DSW_SHIFT_W-2:0], din_s};

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (frame_fall) begin // [RULE3] [RULE7]
          next_state = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (frame_n_s) begin // [RULE5]
          next_state = ST_IDLE;
        end else if (sclk_fall && bit_cnt == FRAME_BITS - 5'h01) begin // [RULE4] [RULE9]
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        // Further clocks are ignored until frame select goes high again
        if (frame_n_s) begin // [RULE7]
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // A word is taken on the final counted fall; an early rise drops it
  wire load_word = (state == ST_SHIFT) && (next_state == ST_DONE);
  wire drop_frame = (state == ST_SHIFT) && frame_n_s;
  reg [`DSW_CODE_W-1:0] next_code;
  reg [`DSW_MODE_W-1:0] next_mode;

  // Mode bits come first on the wire; code and mode load together whatever the mode bits hold
  always @* begin
    next_code = dac_code_out;
    next_mode = mode_out;
    if (LONG_FRAME) begin
      next_mode = shifted[`DSW_MODE_POS+`DSW_MODE_W-1:`DSW_MODE_POS]; // [RULE8]
      next_code = shifted[`DSW_CODE_W-1:0]; // [RULE8]
    end else begin
      // The short variant carries a 14-bit code, padded at the top
      next_mode = shifted[15:14]; // [RULE8]
      next_code = {2'h0, shifted[13:0]}; // [RULE8]
    end
  end

  // Edge detectors start at the idle levels of their pins
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      sclk_d <= 1'b1;
    end else begin
      sclk_d <= sclk_s;
    end
  end

  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      frame_n_d <= 1'b1;
    end else begin
      frame_n_d <= frame_n_s;
    end
  end

  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Cleared whenever a frame is not being shifted, so each frame counts from zero
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      bit_cnt <= 5'h00;
    end else if (state != ST_SHIFT || next_state != ST_SHIFT) begin
      bit_cnt <= 5'h00; // [RULE10]
    end else if (sclk_fall) begin
      bit_cnt <= bit_cnt + 5'h01; // [RULE1]
    end
  end

  // Bits are only taken while frame select is still low
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      shift <= 24'h000000;
    end else if (state == ST_SHIFT && sclk_fall && !frame_n_s) begin
      shift <= shifted; // [RULE2]
    end
  end

  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      busy_out <= 1'b0;
    end else begin
      busy_out <= (next_state == ST_SHIFT); // [RULE3]
    end
  end

  // One-cycle pulse; the partial word in the shifter is simply left unused
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      abort_out <= 1'b0;
    end else begin
      abort_out <= drop_frame; // [RULE5]
    end
  end

  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      update_out <= 1'b0;
    end else begin
      update_out <= load_word; // [RULE4]
    end
  end

  // An aborted frame never reaches these loads, so code and mode hold
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      dac_code_out <= `DSW_CODE_RESET;
    end else if (load_word) begin
      dac_code_out <= next_code; // [RULE4] [RULE5]
    end
  end

  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      mode_out <= `DSW_MODE_RESET;
    end else if (load_word) begin
      mode_out <= next_mode; // [RULE4] [RULE5]
    end
  end
endmodule

// ---- inc/dsw_map.vh ----
// Constants of the serial write port: frame lengths and word layout.
// Included by the port design file only; definitions only.
`ifndef DSW_MAP_VH
`define DSW_MAP_VH
`define DSW_BITS_SHORT 5'h10
`define DSW_BITS_LONG 5'h18
`define DSW_CNT_W 5
`define DSW_SHIFT_W 24
`define DSW_MODE_POS 16
`define DSW_MODE_W 2
`define DSW_CODE_W 16
`define DSW_CODE_RESET 16'h0000
`define DSW_MODE_RESET 2'h0
`endif

// ---- hw/dsw_sync.v ----
// Two-flip-flop synchroniser for one pin.
// Assumes the pin is asynchronous to clk_in.
`timescale 1ns/1ps
module dsw_sync #(
  parameter RESET_VAL = 1'b0
) (
  input wire clk_in,
  input wire reset_in,
  input wire pin_in,
  output reg level_out
);
  reg stage1;
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      // Reset to the pin's idle level, so no edge is seen on release
      stage1 <= RESET_VAL;
      level_out <= RESET_VAL;
    end else begin
      stage1 <= pin_in;
      level_out <= stage1;
    end
  end
endmodule

// ---- verification/dsw_port_assertions.sv ----
// Checker of the serial write port outputs.
// Bound to dsw_port; sees its ports only.
`timescale 1ns/1ps
module dsw_port_assertions (
  input wire clk_in,
  input wire reset_in,
  input wire frame_n_in,
  input wire sclk_in,
  input wire din_in,
  input wire [15:0] dac_code_out,
  input wire [1:0] mode_out,
  input wire update_out,
  input wire abort_out,
  input wire busy_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  sequence s_idle; frame_n_in[*8]; endsequence
  a_idle_quiet: assert property (s_idle |-> !update_out && !busy_out) else $error("idle");
  a_busy_start: assert property ($rose(busy_out) |-> !$past(frame_n_in, 2)) else $error("start");
  a_code_hold: assert property (!update_out |-> $stable(dac_code_out)) else $error("code");
  a_mode_hold: assert property (!update_out |-> $stable(mode_out)) else $error("mode");
  a_upd_pulse: assert property (update_out |=> !update_out) else $error("pulse");
  a_upd_busy: assert property (update_out |-> $past(busy_out)) else $error("upd");
  a_abort_high: assert property (abort_out |-> $past(frame_n_in)) else $error("abort");
  a_no_both: assert property (!(update_out && abort_out)) else $error("both");
endmodule
bind dsw_port dsw_port_assertions chk_u (.clk_in(clk_in), .reset_in(reset_in),
  .frame_n_in(frame_n_in), .sclk_in(sclk_in), .din_in(din_in), .dac_code_out(dac_code_out),
  .mode_out(mode_out), .update_out(update_out), .abort_out(abort_out), .busy_out(busy_out));

// ---- verification/dsw_host.sv ----
// Host model driving frame select, serial clock and data.
// Calls start on a falling edge of the system clock.
`timescale 1ns/1ps
module dsw_host (
  output logic frame_n_out,
  output logic sclk_out,
  output logic din_out
);
  initial begin
    frame_n_out = 1;
    sclk_out = 1;
    din_out = 0;
  end
  // Sends the top n bits of w; fewer than a frame makes an abort
  task automatic send(input logic [23:0] w, input int n);
    frame_n_out = 0;
    #40;
    for (int i = 23; i > 23 - n; i--) begin
      din_out = w[i];
      sclk_out = 1;
      #40 sclk_out = 0;
      #40;
    end
    sclk_out = 1;
    #40 frame_n_out = 1;
    din_out = ~din_out;
    #80;
  endtask
endmodule

// ---- verification/tb_dsw_port.sv ----
// Self-checking bench of the serial write port, long and short frames.
// Host model drives the pins.
`timescale 1ns/1ps
module tb_dsw_port;
  logic clk_in = 0;
  logic reset_in = 1;
  wire f, s, d, up, ab, busy;
  wire [15:0] code;
  wire [1:0] mode;
  wire [15:0] code16;
  wire [1:0] mode16;
  int errors = 0, checked = 0, ups = 0, abs = 0;
  logic [23:0] rows [4] = '{24'hFC3A5C, 24'h01FFFF, 24'h020001, 24'h038000};
  initial forever #5 clk_in = ~clk_in;
  dsw_host host_u (.frame_n_out(f), .sclk_out(s), .din_out(d));
  dsw_port #(.LONG_FRAME(1)) dut_u (.clk_in(clk_in), .reset_in(reset_in), .frame_n_in(f),
    .sclk_in(s), .din_in(d), .dac_code_out(code), .mode_out(mode), .update_out(up),
    .abort_out(ab), .busy_out(busy));
  // Short variant on the same pins; it finishes its frame after 16 falls
  dsw_port #(.LONG_FRAME(0)) dut_u16 (.clk_in(clk_in), .reset_in(reset_in), .frame_n_in(f),
    .sclk_in(s), .din_in(d), .dac_code_out(code16), .mode_out(mode16), .update_out(),
    .abort_out(), .busy_out());
  always @(posedge clk_in) begin
    ups += (up === 1'b1);
    abs += (ab === 1'b1);
  end
  task chk(input logic [19:0] got, input logic [19:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task close_out;
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge clk_in);
    reset_in = 0;
    chk({1'b0, busy, mode, code}, 20'h0);
    repeat (3) @(negedge clk_in);
    foreach (rows[i]) begin
      ups = 0;
      host_u.send(rows[i], 24);
      chk({ups[1:0], mode, code}, {2'h1, rows[i][17:0]});
      $display("row %0d done", i);
    end
    ups = 0;
    host_u.send(24'h03ABCD, 23);
    chk({ups[1:0], mode, code}, {2'h0, rows[3][17:0]});
    chk(abs[19:0], 20'h1);
    host_u.send(24'hB12300, 16);
    chk({2'h0, mode16, code16}, {4'h2, 16'h3123});
    host_u.send(24'h4FFF00, 15);
    chk({2'h0, mode16, code16}, {4'h2, 16'h3123});
    $display("short frame test done");
    host_u.send(24'h02BEEF, 24);
    chk({ups[1:0], mode, code}, {2'h1, 18'h2BEEF});
    $display("abort test done");
    reset_in = 1;
    repeat (2) @(negedge clk_in);
    reset_in = 0;
    chk({1'b0, busy, mode, code}, 20'h0);
    repeat (3) @(negedge clk_in);
    ups = 0;
    host_u.send(24'h010001, 24);
    chk({ups[1:0], mode, code}, {2'h1, 18'h10001});
    $display("reset test done");
    close_out;
  end
endmodule
